// file: verilog/sild_pkg.sv
// shared widths, counts and types for the serial-in latched output driver
package sild_pkg;
    localparam int unsigned SILD_WIDTH       = 8;
    localparam int unsigned SILD_FIFO_DEPTH  = 8;
    localparam int unsigned SILD_PTR_W       = 3;
    localparam logic [1:0]  SILD_HALF_CYCLES = 2'h2;
    localparam logic [3:0]  SILD_INIT_CYCLES = 4'h8;
    localparam logic [2:0]  SILD_LAST_BIT    = 3'h7;
    localparam logic [7:0]  SILD_RESET_WORD  = 8'h00;

    typedef logic [SILD_WIDTH-1:0] sild_word_t;

    typedef enum logic [2:0] {
        SILD_INIT,
        SILD_IDLE,
        SILD_BIT_LOW,
        SILD_BIT_HIGH,
        SILD_LATCH_HIGH,
        SILD_LATCH_LOW
    } sild_state_t;
endpackage

// file: verilog/sild_link_if.sv
// link wires between controller and driver
`timescale 1ns/1ps
interface sild_link_if;
    logic shift_clock;
    logic latch_clock;
    logic serial_in;
    logic clear_n;
    logic output_enable_n;
    logic serial_out;

    modport host (
        output shift_clock,
        output latch_clock,
        output serial_in,
        output clear_n,
        output output_enable_n,
        input  serial_out
    );

    modport device (
        input  shift_clock,
        input  latch_clock,
        input  serial_in,
        input  clear_n,
        input  output_enable_n,
        output serial_out
    );
endinterface

// file: verilog/sild_fifo.sv
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/1ps
module sild_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned PTR_W = 3
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W:0]              wr_ptr;
        logic [PTR_W:0]              rd_ptr;
    } sild_fifo_st_t;

    sild_fifo_st_t s;
    sild_fifo_st_t next_s;

    // extra pointer bit tells full from empty
    assign in_ready  = !((s.wr_ptr[PTR_W] != s.rd_ptr[PTR_W]) && (s.wr_ptr[PTR_W-1:0] == s.rd_ptr[PTR_W-1:0]));
    assign out_valid = (s.wr_ptr != s.rd_ptr);
    assign out_data  = s.mem[s.rd_ptr[PTR_W-1:0]];

    always_comb begin
        next_s = s;
        if (in_valid && in_ready) begin
            next_s.mem[s.wr_ptr[PTR_W-1:0]] = in_data;
            next_s.wr_ptr = s.wr_ptr + 1'b1;
        end
        if (out_valid && out_ready) begin
            next_s.rd_ptr = s.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// file: verilog/sild_device.sv
// driver end: shift register, storage register and open-drain output stage
`timescale 1ns/1ps
module sild_device (
    sild_link_if.device          link,
    output sild_pkg::sild_word_t drain_o,
    output sild_pkg::sild_word_t drain_oe,
    output sild_pkg::sild_word_t stored
);
    import sild_pkg::*;

    // two clocks from the controller, so state splits per domain
    typedef struct packed {
        sild_word_t shift;
    } sild_shift_st_t;

    typedef struct packed {
        sild_word_t storage;
    } sild_store_st_t;

    sild_shift_st_t sh;
    sild_shift_st_t next_sh;
    sild_store_st_t st;
    sild_store_st_t next_st;
    sild_word_t     buffer;

    always_comb begin
        next_sh = sh;
        next_sh.shift = {sh.shift[SILD_WIDTH-2:0], link.serial_in};
    end

    // clear acts without a clock edge: the shift clock may be stopped
    always_ff @(posedge link.shift_clock or negedge link.clear_n) begin
        if (!link.clear_n) begin
            sh <= '0;
        end else begin
            sh <= next_sh;
        end
    end

    always_comb begin
        next_st = st;
        next_st.storage = sh.shift;
    end

    // storage samples the shift register directly, so the controller must
    // keep the latch edge clear of any shift edge
    always_ff @(posedge link.latch_clock or negedge link.clear_n) begin
        if (!link.clear_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.serial_out = sh.shift[SILD_WIDTH-1];
    assign stored          = st.storage;

    // transparent path, no clock: dimming follows the enable at once
    assign buffer   = link.output_enable_n ? SILD_RESET_WORD : st.storage;
    assign drain_o  = SILD_RESET_WORD;
    assign drain_oe = buffer;
endmodule

// file: verilog/sild_host.sv
// controller end: buffers patterns, shifts them out and latches them
`timescale 1ns/1ps
module sild_host (
    input  wire logic            ref_clk,
    input  wire logic            nrst,
    sild_link_if.host            link,
    input  wire logic            wr_valid,
    output logic                 wr_ready,
    input  sild_pkg::sild_word_t wr_data,
    input  sild_pkg::sild_word_t pwm_duty,
    output logic                 busy
);
    import sild_pkg::*;

    typedef struct packed {
        sild_state_t state;
        logic [1:0]  div;
        logic [2:0]  bit_cnt;
        logic [3:0]  init_cnt;
        sild_word_t  word;
        sild_word_t  pwm_cnt;
        logic        sck;
        logic        lck;
        logic        sdi;
        logic        clr_n;
        logic        oe_n;
    } sild_host_st_t;

    sild_host_st_t s;
    sild_host_st_t next_s;
    logic          q_valid;
    logic          q_ready;
    sild_word_t    q_data;
    logic          half_done;

    sild_fifo #(
        .WIDTH (SILD_WIDTH),
        .DEPTH (SILD_FIFO_DEPTH),
        .PTR_W (SILD_PTR_W)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );

    assign half_done = (s.div == SILD_HALF_CYCLES - 2'h1);
    // fifo drains only between patterns, so a slow link fills it
    assign q_ready   = (s.state == SILD_IDLE);
    assign busy      = (s.state != SILD_IDLE) || q_valid;

    always_comb begin
        next_s = s;
        next_s.div = half_done ? 2'h0 : s.div + 2'h1;
        next_s.pwm_cnt = s.pwm_cnt + 8'h01;
        // duty 0xFF leaves one dark step in 256
        next_s.oe_n = !(s.pwm_cnt < pwm_duty);
        case (s.state)
            SILD_INIT: begin
                next_s.clr_n = 1'b0;
                next_s.init_cnt = s.init_cnt + 4'h1;
                if (s.init_cnt == SILD_INIT_CYCLES - 4'h1) begin
                    next_s.clr_n = 1'b1;
                    next_s.state = SILD_IDLE;
                end
            end
            SILD_IDLE: begin
                next_s.div = 2'h0;
                if (q_valid) begin
                    next_s.word = q_data << 1;
                    next_s.sdi = q_data[SILD_WIDTH-1];
                    next_s.bit_cnt = SILD_LAST_BIT;
                    next_s.state = SILD_BIT_LOW;
                end
            end
            SILD_BIT_LOW: begin
                if (half_done) begin
                    next_s.sck = 1'b1;
                    next_s.state = SILD_BIT_HIGH;
                end
            end
            SILD_BIT_HIGH: begin
                if (half_done) begin
                    next_s.sck = 1'b0;
                    if (s.bit_cnt == 3'h0) begin
                        next_s.lck = 1'b1;
                        next_s.state = SILD_LATCH_HIGH;
                    end else begin
                        next_s.sdi = s.word[SILD_WIDTH-1];
                        next_s.word = s.word << 1;
                        next_s.bit_cnt = s.bit_cnt - 3'h1;
                        next_s.state = SILD_BIT_LOW;
                    end
                end
            end
            SILD_LATCH_HIGH: begin
                if (half_done) begin
                    next_s.lck = 1'b0;
                    next_s.state = SILD_LATCH_LOW;
                end
            end
            SILD_LATCH_LOW: begin
                if (half_done) begin
                    next_s.state = SILD_IDLE;
                end
            end
            default: begin
                next_s.state = SILD_INIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s <= '0;
            s.state <= SILD_INIT;
            s.oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign link.shift_clock     = s.sck;
    assign link.latch_clock     = s.lck;
    assign link.serial_in       = s.sdi;
    assign link.clear_n         = s.clr_n;
    assign link.output_enable_n = s.oe_n;
endmodule

// file: verification/sild_link_assertions.sv
// link protocol checks between controller and driver ends
`timescale 1ns/1ps
module sild_link_assertions (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic shift_clock,
    input wire logic latch_clock,
    input wire logic serial_in,
    input wire logic clear_n,
    input wire logic output_enable_n,
    input wire logic serial_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_clear_zero: assert property (!clear_n |-> !serial_out)
        else $error("serial out high while cleared");
    chk_out_stable: assert property (!$rose(shift_clock) && clear_n && $past(clear_n) |-> $stable(serial_out))
        else $error("serial out moved without shift edge");
    chk_shift_high: assert property ($rose(shift_clock) |-> shift_clock[*2] ##1 !shift_clock)
        else $error("shift pulse width wrong");
    chk_data_hold: assert property ($rose(shift_clock) |-> $stable(serial_in) ##1 $stable(serial_in))
        else $error("serial data moved around shift edge");
    chk_no_overlap: assert property (!(shift_clock && latch_clock))
        else $error("shift and latch clocks overlap");
    chk_latch_pulse: assert property ($rose(latch_clock) |-> latch_clock[*2] ##1 !latch_clock)
        else $error("latch pulse width wrong");
    chk_latch_after: assert property ($rose(latch_clock) |-> $past(shift_clock))
        else $error("latch not right after last shift");
    chk_init_clear: assert property ($rose(nrst) |-> !clear_n[*8])
        else $error("clear released too early");
endmodule

// file: verification/serial_in_latched_output_driver_bench.sv
// self-checking bench joining controller and driver ends
`timescale 1ns/1ps
module serial_in_latched_output_driver_bench;
    import sild_pkg::*;
    logic       ref_clk;
    logic       nrst;
    logic       wr_valid;
    logic       wr_ready;
    sild_word_t wr_data;
    sild_word_t pwm_duty;
    logic       busy;
    sild_word_t drain_oe;
    sild_word_t drain_o;
    sild_word_t stored;
    sild_word_t chain_stored;
    logic       full_seen;
    int         failures;
    int         tests_run;
    sild_word_t pats[5] = '{8'hA5, 8'h01, 8'h80, 8'hFF, 8'h3C};

    sild_link_if link();
    sild_host sild_host_i (.ref_clk(ref_clk), .nrst(nrst), .link(link), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .pwm_duty(pwm_duty), .busy(busy));
    sild_device sild_device_i (.link(link), .drain_o(drain_o), .drain_oe(drain_oe), .stored(stored));
    // second driver chained behind the first, sharing both clocks and the clear
    sild_link_if chain();
    assign chain.shift_clock     = link.shift_clock;
    assign chain.latch_clock     = link.latch_clock;
    assign chain.clear_n         = link.clear_n;
    assign chain.output_enable_n = link.output_enable_n;
    assign chain.serial_in       = link.serial_out;
    sild_device sild_device_next_i (.link(chain), .drain_o(), .drain_oe(), .stored(chain_stored));
    sild_link_assertions sild_link_assertions_i (.ref_clk(ref_clk), .nrst(nrst),
        .shift_clock(link.shift_clock), .latch_clock(link.latch_clock), .serial_in(link.serial_in),
        .clear_n(link.clear_n), .output_enable_n(link.output_enable_n), .serial_out(link.serial_out));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // refusal seen while filling the buffer
    always @(posedge ref_clk) begin
        if (wr_valid && wr_ready === 1'b0)
            full_seen = 1'b1;
    end

    task automatic results;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input sild_word_t got, input sild_word_t exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // valid stays up after the accepting edge; caller drops it
    task automatic wr(input sild_word_t w);
        wr_valid = 1'b1;
        wr_data = w;
        for (int n = 0; n < 500 && wr_ready !== 1'b1; n++) begin
            @(posedge ref_clk);
            #2;
        end
        if (wr_ready !== 1'b1) begin
            failures++;
            $display("BAD at %0t: write never accepted", $time);
        end
        @(posedge ref_clk);
        #2;
    endtask

    task automatic settle;
        for (int n = 0; n < 3000 && busy !== 1'b0; n++) begin
            @(posedge ref_clk);
            #2;
        end
        if (busy !== 1'b0) begin
            failures++;
            $display("BAD at %0t: controller stuck busy", $time);
        end
        repeat (4) @(posedge ref_clk);
        #2;
    endtask

    initial begin
        #500000;
        failures++;
        results;
    end

    initial begin
        nrst = 1'b0;
        wr_valid = 1'b0;
        wr_data = 8'h00;
        pwm_duty = 8'hFF;
        full_seen = 1'b0;
        failures = 0;
        tests_run = 0;
        repeat (16) @(posedge ref_clk);
        #2;
        nrst = 1'b1;
        check(stored, 8'h00);
        settle;
        foreach (pats[i]) begin
            wr(pats[i]);
            wr_valid = 1'b0;
            settle;
            check(stored, pats[i]);
            check(chain_stored, (i == 0) ? 8'h00 : pats[i-1]);
            check({7'h00, link.serial_out}, {7'h00, pats[i][7]});
            check(drain_oe, link.output_enable_n ? 8'h00 : pats[i]);
            check(drain_o, 8'h00);
        end
        pwm_duty = 8'h00;
        repeat (3) @(posedge ref_clk);
        #2;
        check(drain_oe, 8'h00);
        check(stored, 8'h3C);
        pwm_duty = 8'hFF;
        for (int i = 0; i < 10; i++)
            wr(8'h10 + 8'(i));
        wr_valid = 1'b0;
        check({7'h00, full_seen}, 8'h01);
        settle;
        check(stored, 8'h19);
        check(chain_stored, 8'h18);
        nrst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #2;
        check(stored, 8'h00);
        check(chain_stored, 8'h00);
        check(drain_oe, 8'h00);
        nrst = 1'b1;
        settle;
        wr(8'h5A);
        wr_valid = 1'b0;
        settle;
        check(stored, 8'h5A);
        check(chain_stored, 8'h00);
        results;
    end
endmodule
